/* File: logic/eac_pkg.sv */
// package of the nonvolatile byte access controller: map, fields, timing.
// assumes a single 250 MHz clock shared by the device end and the cpu end.
// Functional notes
// - nine-bit linear byte index, two registers
// - unused index-high and control top bits read zero
// - index undefined at reset; load before access
// - value register feeds writes, receives reads
// - action select: atomic, erase, write, reserved
// - action select writes ignored while strobe set
// - reset clears action select unless programming
// - ready irq held while enabled and idle
// - no ready irq during programming or store
// - write arm self-clears after four cycles
// - strobe starts programming only while armed
// - host polls, loads, arms, strobes in time
// - no programming start during flash writes
// - host keeps global irq off during sequence
// - write strobe self-clears when programming ends
// - write strobe stalls cpu two cycles
// - read strobe fetches byte, stalls four cycles
// - busy blocks reads and index changes
// - host polls strobe zero before reading
// - programming timed from rc oscillator ticks
// - reset does not abort running programming
`default_nettype none

package eac_pkg;

    // geometry
    localparam int unsigned NV_BYTES         = 512;
    localparam int unsigned IDX_W            = 9;

    // cpu i/o offsets
    localparam logic [7:0]  IO_IDX_LO        = 8'h21;
    localparam logic [7:0]  IO_IDX_HI        = 8'h22;
    localparam logic [7:0]  IO_VALUE         = 8'h23;
    localparam logic [7:0]  IO_CTRL          = 8'h24;

    // control register fields
    localparam int unsigned CTRL_RD          = 0;
    localparam int unsigned CTRL_WS          = 1;
    localparam int unsigned CTRL_ARM         = 2;
    localparam int unsigned CTRL_RIE         = 3;
    localparam int unsigned CTRL_PM_LO       = 4;
    localparam int unsigned CTRL_PM_HI       = 5;

    typedef enum logic [1:0] {
        PM_ATOMIC = 2'h0,
        PM_ERASE  = 2'h1,
        PM_WRITE  = 2'h2,
        PM_RSVD   = 2'h3
    } eac_pm_e;

    localparam logic [1:0]  PM_RESET         = 2'h0;
    localparam logic [7:0]  ERASED_BYTE      = 8'hFF;

    // timing
    localparam int unsigned CLK_PERIOD_NS    = 4;
    localparam int unsigned NV_WRITE_RC_CYC  = 26368;
    localparam int unsigned NV_WRITE_TIME_NS = 3300000;
    localparam int unsigned RC_DIV           = NV_WRITE_TIME_NS / (NV_WRITE_RC_CYC * CLK_PERIOD_NS);
    localparam int unsigned NV_SPLIT_TIME_NS = 1800000;
    localparam int unsigned NV_SPLIT_RC_CYC  = NV_SPLIT_TIME_NS / (RC_DIV * CLK_PERIOD_NS);
    localparam int unsigned ARM_WINDOW_CYC   = 4;
    localparam int unsigned WR_STALL_CYC     = 2;
    localparam int unsigned RD_STALL_CYC     = 4;

    // host wishbone offsets and fields
    localparam logic [7:0]  HW_CMD           = 8'h00;
    localparam logic [7:0]  HW_INDEX         = 8'h04;
    localparam logic [7:0]  HW_DATA          = 8'h08;
    localparam logic [7:0]  HW_STAT          = 8'h0C;
    localparam logic [7:0]  HW_CFG           = 8'h10;
    localparam int unsigned CMD_WRITE        = 0;
    localparam int unsigned CMD_READ         = 1;
    localparam int unsigned CFG_RIE          = 0;
    localparam int unsigned CFG_GIE          = 1;
    localparam int unsigned STAT_BUSY        = 0;
    localparam int unsigned STAT_IRQ         = 1;
    localparam int unsigned STAT_RDV         = 2;

endpackage : eac_pkg

`default_nettype wire

/* File: logic/eac_if.sv */
// cpu i/o port between the access controller and the controlling cpu end.
// assumes both ends run on the same clock; all strobes are one-cycle pulses.
`default_nettype none

interface eac_if;
    logic [7:0] io_addr;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       stall;
    logic       irq;
    logic       gie;

    modport dev (
        input  io_addr, io_wr, io_rd, io_wdata, gie,
        output io_rdata, stall, irq
    );

    modport cpu (
        output io_addr, io_wr, io_rd, io_wdata, gie,
        input  io_rdata, stall, irq
    );
endinterface : eac_if

`default_nettype wire

/* File: logic/eac_dev.sv */
// device end: index, value and control registers plus the byte array.
// assumes the cpu end issues at most one i/o access per cycle.
`default_nettype none

module eac_dev
    import eac_pkg::*;
#(
    parameter int unsigned ATOMIC_TICKS = NV_WRITE_RC_CYC,
    parameter int unsigned SPLIT_TICKS  = NV_SPLIT_RC_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // cpu port
    eac_if.dev        io,
    // flash side status
    input  wire logic flash_selfprog_active_i,
    input  wire logic flash_store_op_i,
    output logic      prog_busy_o
);

    logic [7:0]       mem [NV_BYTES];
    logic [IDX_W-1:0] idx_ff;
    logic [7:0]       value_ff;
    logic [1:0]       pm_ff;
    logic             rie_ff;
    logic             arm_ff;
    logic [2:0]       arm_cnt_ff;
    logic             ws_ff;
    logic             rd_ff;
    logic [2:0]       stall_cnt_ff;
    logic [4:0]       rc_div_ff;
    logic [14:0]      prog_cnt_ff;
    logic [IDX_W-1:0] lat_idx_ff;
    logic [7:0]       lat_val_ff;
    logic [1:0]       lat_pm_ff;
    logic [7:0]       rdata_ff;
    logic             irq_ff;

    logic wr_act;
    logic rd_act;
    logic ctrl_wr;
    logic rd_start;
    logic ws_start;
    logic rc_tick;
    logic prog_done;

    assign wr_act    = io.io_wr && (stall_cnt_ff == 3'h0);
    assign rd_act    = io.io_rd && (stall_cnt_ff == 3'h0);
    assign ctrl_wr   = wr_act && (io.io_addr == IO_CTRL);
    assign rd_start  = ctrl_wr && io.io_wdata[CTRL_RD] && !ws_ff;
    assign ws_start  = ctrl_wr && io.io_wdata[CTRL_WS] && arm_ff && !ws_ff
                       && !flash_selfprog_active_i && !flash_store_op_i
                       && (io.io_wdata[CTRL_PM_HI:CTRL_PM_LO] != PM_RSVD);
    assign rc_tick   = (rc_div_ff == 5'(RC_DIV - 1));
    assign prog_done = ws_ff && rc_tick && (prog_cnt_ff == 15'h1);

    // rc oscillator tick divider
    always_ff @(posedge clk_i) begin
        if (rc_tick) begin
            rc_div_ff <= 5'h0;
        end else if (rst_i && !ws_ff) begin
            rc_div_ff <= 5'h0;
        end else begin
            rc_div_ff <= rc_div_ff + 5'h1;
        end
    end

    // byte index, held while programming
    always_ff @(posedge clk_i) begin
        if (wr_act && !ws_ff && io.io_addr == IO_IDX_LO) begin
            idx_ff[7:0] <= io.io_wdata;
        end
        if (wr_act && !ws_ff && io.io_addr == IO_IDX_HI) begin
            idx_ff[8] <= io.io_wdata[0];
        end
    end

    // value register
    always_ff @(posedge clk_i) begin
        if (rd_start) begin
            value_ff <= mem[idx_ff];
        end else if (wr_act && io.io_addr == IO_VALUE) begin
            value_ff <= io.io_wdata;
        end
    end

    // action select and irq enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            if (ws_ff) begin
                pm_ff  <= pm_ff;
                rie_ff <= rie_ff;
            end else begin
                pm_ff  <= PM_RESET;
                rie_ff <= 1'b0;
            end
        end else if (ctrl_wr) begin
            rie_ff <= io.io_wdata[CTRL_RIE];
            if (!ws_ff) begin
                pm_ff <= io.io_wdata[CTRL_PM_HI:CTRL_PM_LO];
            end
        end
    end

    // write arm window
    always_ff @(posedge clk_i) begin
        if (rst_i && !ws_ff) begin
            arm_ff     <= 1'b0;
            arm_cnt_ff <= 3'h0;
        end else if (ctrl_wr && io.io_wdata[CTRL_ARM]) begin
            arm_ff     <= 1'b1;
            arm_cnt_ff <= 3'(ARM_WINDOW_CYC);
        end else if (arm_cnt_ff == 3'h1) begin
            arm_ff     <= 1'b0;
            arm_cnt_ff <= 3'h0;
        end else if (arm_cnt_ff != 3'h0) begin
            arm_cnt_ff <= arm_cnt_ff - 3'h1;
        end
    end

    // write strobe and programming timer
    always_ff @(posedge clk_i) begin
        if (prog_done) begin
            ws_ff <= 1'b0;
        end else if (rst_i) begin
            if (ws_ff) begin
                ws_ff <= 1'b1;
            end else begin
                ws_ff <= 1'b0;
            end
        end else if (ws_start) begin
            ws_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ws_start && !rst_i) begin
            lat_idx_ff  <= idx_ff;
            lat_val_ff  <= value_ff;
            lat_pm_ff   <= io.io_wdata[CTRL_PM_HI:CTRL_PM_LO];
            prog_cnt_ff <= (io.io_wdata[CTRL_PM_HI:CTRL_PM_LO] == PM_ATOMIC)
                           ? 15'(ATOMIC_TICKS) : 15'(SPLIT_TICKS);
        end else if (ws_ff && rc_tick) begin
            prog_cnt_ff <= prog_cnt_ff - 15'h1;
        end
    end

    // array update at the end of the programming time
    always_ff @(posedge clk_i) begin
        if (prog_done) begin
            unique case (lat_pm_ff)
                PM_ATOMIC: mem[lat_idx_ff] <= lat_val_ff;
                PM_ERASE:  mem[lat_idx_ff] <= ERASED_BYTE;
                PM_WRITE:  mem[lat_idx_ff] <= mem[lat_idx_ff] & lat_val_ff;
                default:   mem[lat_idx_ff] <= mem[lat_idx_ff];
            endcase
        end
    end

    // read strobe, one cycle high
    always_ff @(posedge clk_i) begin
        if (rst_i && !ws_ff) begin
            rd_ff <= 1'b0;
        end else begin
            rd_ff <= rd_start;
        end
    end

    // cpu stall counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stall_cnt_ff <= 3'h0;
        end else if (rd_start) begin
            stall_cnt_ff <= 3'(RD_STALL_CYC);
        end else if (ws_start) begin
            stall_cnt_ff <= 3'(WR_STALL_CYC);
        end else if (stall_cnt_ff != 3'h0) begin
            stall_cnt_ff <= stall_cnt_ff - 3'h1;
        end
    end

    // register read data, one cycle after the read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= 8'h00;
        end else if (rd_act) begin
            unique case (io.io_addr)
                IO_IDX_LO: rdata_ff <= idx_ff[7:0];
                IO_IDX_HI: rdata_ff <= {7'h00, idx_ff[8]};
                IO_VALUE:  rdata_ff <= value_ff;
                IO_CTRL:   rdata_ff <= {2'h0, pm_ff, rie_ff, arm_ff, ws_ff, rd_ff};
                default:   rdata_ff <= 8'h00;
            endcase
        end
    end

    // ready interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= rie_ff && io.gie && !ws_ff && !flash_store_op_i;
        end
    end

    assign io.io_rdata  = rdata_ff;
    assign io.stall     = (stall_cnt_ff != 3'h0);
    assign io.irq       = irq_ff;
    assign prog_busy_o  = ws_ff;

endmodule : eac_dev

`default_nettype wire

/* File: logic/eac_host.sv */
// cpu end: runs byte read and program sequences ordered over wishbone.
// assumes a classic wishbone master on the same clock.
`default_nettype none

module eac_host
    import eac_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // status
    input  wire logic        flash_selfprog_active_i,
    output logic             irq_o,
    // device port
    eac_if.cpu               io
);

    typedef enum logic [3:0] {
        H_IDLE, H_POLL, H_POLL_W, H_POLL_C, H_IDX_HI, H_IDX_LO, H_VAL,
        H_ARM, H_STROBE, H_RD_STROBE, H_GAP, H_STALL, H_RD_VAL, H_RD_W, H_RD_C
    } eac_hst_e;

    eac_hst_e         st_ff;
    logic             ack_ff;
    logic [31:0]      dat_ff;
    logic             op_rd_ff;
    logic [1:0]       pm_ff;
    logic [IDX_W-1:0] index_ff;
    logic [7:0]       data_ff;
    logic             rie_ff;
    logic             gie_en_ff;
    logic             rdv_ff;
    logic [7:0]       io_addr_ff;
    logic             io_wr_ff;
    logic             io_rd_ff;
    logic [7:0]       io_wdata_ff;

    logic wb_req;
    logic wb_wr;
    logic go;

    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_wr  = wb_req && wb_we_i && ack_ff && wb_sel_i[0];
    assign go     = wb_wr && (wb_adr_i == HW_CMD) && (st_ff == H_IDLE)
                    && (wb_dat_i[CMD_WRITE] || wb_dat_i[CMD_READ]);

    // wishbone answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= wb_req && !ack_ff;
            if (wb_req && !ack_ff) begin
                unique case (wb_adr_i)
                    HW_CMD:   dat_ff <= {26'h0, pm_ff, 4'h0};
                    HW_INDEX: dat_ff <= {23'h0, index_ff};
                    HW_DATA:  dat_ff <= {24'h0, data_ff};
                    HW_STAT:  dat_ff <= {29'h0, rdv_ff, io.irq, st_ff != H_IDLE};
                    HW_CFG:   dat_ff <= {30'h0, gie_en_ff, rie_ff};
                    default:  dat_ff <= 32'h0;
                endcase
            end
        end
    end

    // software settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pm_ff     <= PM_RESET;
            index_ff  <= '0;
            data_ff   <= 8'h00;
            rie_ff    <= 1'b0;
            gie_en_ff <= 1'b0;
            op_rd_ff  <= 1'b0;
        end else begin
            if (go) begin
                op_rd_ff <= !wb_dat_i[CMD_WRITE];
                pm_ff    <= wb_dat_i[CTRL_PM_HI:CTRL_PM_LO];
            end
            if (wb_wr && wb_adr_i == HW_INDEX && st_ff == H_IDLE) begin
                index_ff[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) begin
                    index_ff[8] <= wb_dat_i[8];
                end
            end
            if (st_ff == H_RD_C) begin
                data_ff <= io.io_rdata;
            end else if (wb_wr && wb_adr_i == HW_DATA && st_ff == H_IDLE) begin
                data_ff <= wb_dat_i[7:0];
            end
            if (wb_wr && wb_adr_i == HW_CFG) begin
                rie_ff    <= wb_dat_i[CFG_RIE];
                gie_en_ff <= wb_dat_i[CFG_GIE];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || go) begin
            rdv_ff <= 1'b0;
        end else if (st_ff == H_RD_C) begin
            rdv_ff <= 1'b1;
        end
    end

    // access sequencer; each access leaves as a one-cycle strobe
    always_ff @(posedge clk_i) begin
        io_wr_ff <= 1'b0;
        io_rd_ff <= 1'b0;
        if (rst_i) begin
            st_ff       <= H_IDLE;
            io_addr_ff  <= 8'h00;
            io_wdata_ff <= 8'h00;
        end else begin
            unique case (st_ff)
                H_IDLE: if (go) begin
                    st_ff <= H_POLL;
                end
                H_POLL: if (!io.stall) begin
                    io_rd_ff   <= 1'b1;
                    io_addr_ff <= IO_CTRL;
                    st_ff      <= H_POLL_W;
                end
                H_POLL_W: st_ff <= H_POLL_C;
                H_POLL_C: begin
                    if (io.io_rdata[CTRL_WS] || (!op_rd_ff && flash_selfprog_active_i)) begin
                        st_ff <= H_POLL;
                    end else begin
                        st_ff <= H_IDX_HI;
                    end
                end
                H_IDX_HI: if (!io.stall) begin
                    io_wr_ff    <= 1'b1;
                    io_addr_ff  <= IO_IDX_HI;
                    io_wdata_ff <= {7'h00, index_ff[8]};
                    st_ff       <= H_IDX_LO;
                end
                H_IDX_LO: if (!io.stall) begin
                    io_wr_ff    <= 1'b1;
                    io_addr_ff  <= IO_IDX_LO;
                    io_wdata_ff <= index_ff[7:0];
                    st_ff       <= op_rd_ff ? H_RD_STROBE : H_VAL;
                end
                H_VAL: if (!io.stall) begin
                    io_wr_ff    <= 1'b1;
                    io_addr_ff  <= IO_VALUE;
                    io_wdata_ff <= data_ff;
                    st_ff       <= H_ARM;
                end
                H_ARM: if (!io.stall) begin
                    io_wr_ff    <= 1'b1;
                    io_addr_ff  <= IO_CTRL;
                    io_wdata_ff <= {2'h0, pm_ff, rie_ff, 1'b1, 1'b0, 1'b0};
                    st_ff       <= H_STROBE;
                end
                H_STROBE: begin
                    io_wr_ff    <= 1'b1;
                    io_addr_ff  <= IO_CTRL;
                    io_wdata_ff <= {2'h0, pm_ff, rie_ff, 1'b1, 1'b1, 1'b0};
                    st_ff       <= H_GAP;
                end
                H_RD_STROBE: if (!io.stall) begin
                    io_wr_ff    <= 1'b1;
                    io_addr_ff  <= IO_CTRL;
                    io_wdata_ff <= {2'h0, pm_ff, rie_ff, 1'b0, 1'b0, 1'b1};
                    st_ff       <= H_GAP;
                end
                H_GAP: st_ff <= H_STALL;
                H_STALL: if (!io.stall) begin
                    st_ff <= op_rd_ff ? H_RD_VAL : H_IDLE;
                end
                H_RD_VAL: begin
                    io_rd_ff   <= 1'b1;
                    io_addr_ff <= IO_VALUE;
                    st_ff      <= H_RD_W;
                end
                H_RD_W: st_ff <= H_RD_C;
                H_RD_C: st_ff <= H_IDLE;
            endcase
        end
    end

    assign io.io_addr  = io_addr_ff;
    assign io.io_wr    = io_wr_ff;
    assign io.io_rd    = io_rd_ff;
    assign io.io_wdata = io_wdata_ff;
    assign io.gie      = gie_en_ff && (st_ff == H_IDLE);
    assign wb_dat_o    = dat_ff;
    assign wb_ack_o    = ack_ff;
    assign irq_o       = io.irq;

endmodule : eac_host

`default_nettype wire

/* File: testbench/eac_io_assertions.sv */
// checker on the cpu i/o port between the device end and the cpu end.
// assumes one clock; instantiated in the bench top beside the interface.
`default_nettype none

module eac_io_assertions
    import eac_pkg::*;
#(
    parameter int unsigned ATOMIC_TICKS = NV_WRITE_RC_CYC,
    parameter int unsigned SPLIT_TICKS  = NV_SPLIT_RC_CYC
) (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // i/o port
    input wire logic [7:0] io_addr,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       stall,
    input wire logic       irq,
    // device status
    input wire logic       prog_busy_o,
    input wire logic       flash_store_op_i
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MIN_BUSY = (SPLIT_TICKS - 1) * RC_DIV;
    localparam int MAX_BUSY = ATOMIC_TICKS * RC_DIV + 2;

    logic [31:0] busy_cnt_ff;
    logic        ctl_wr;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // cycles spent programming
    always_ff @(posedge clk_i) begin
        busy_cnt_ff <= prog_busy_o ? busy_cnt_ff + 32'h1 : 32'h0;
    end
    assign ctl_wr = io_wr && io_addr == IO_CTRL && !stall;

    write_stall_a: assert property ($rose(prog_busy_o) |-> stall ##1 stall ##1 !stall)
        else $error("write stall not two cycles");
    read_stall_a: assert property (ctl_wr && io_wdata[1:0] == 2'h1 && !prog_busy_o
        |=> stall [*4] ##1 !stall) else $error("read stall not four cycles");
    busy_quiet_a: assert property ($past(prog_busy_o) || $past(flash_store_op_i) |-> !irq)
        else $error("ready irq while busy");
    reserved_bits_a: assert property (io_rd && io_addr == IO_CTRL && !stall
        |=> io_rdata[7:6] == 2'h0) else $error("control top bits not zero");
    flash_block_a: assert property (ctl_wr && io_wdata[CTRL_WS] && flash_store_op_i
        && !prog_busy_o |=> !prog_busy_o) else $error("programming during flash store");
    busy_time_a: assert property ($fell(prog_busy_o) |-> busy_cnt_ff >= 32'(MIN_BUSY)
        && busy_cnt_ff <= 32'(MAX_BUSY)) else $error("programming time off");
    reset_clear_a: assert property ($past(rst_i) && !$past(prog_busy_o) |-> !stall && !irq)
        else $error("reset left stall or irq");
    reset_keep_a: assert property ($past(rst_i) && $past(prog_busy_o) |-> prog_busy_o)
        else $error("reset aborted programming");

    cover property ($rose(prog_busy_o));
    cover property (ctl_wr && io_wdata[1:0] == 2'h1);
    cover property ($past(rst_i) && $past(prog_busy_o));
endmodule // eac_io_assertions

`default_nettype wire

/* File: testbench/eac_bench.sv */
// bench: host end and device end joined by the i/o interface, driven over wishbone.
// assumes shortened programming tick counts.
`default_nettype none

module eac_bench
    import eac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc   = 1'b0;
    logic        wb_stb   = 1'b0;
    logic        wb_we    = 1'b0;
    logic [7:0]  wb_adr   = 8'h00;
    logic [31:0] wb_wdat  = 32'h0;
    logic        selfprog = 1'b0;
    logic        store    = 1'b0;
    logic [31:0] wb_rdat;
    logic [31:0] rd;
    logic        wb_ack;
    logic        irq;
    logic        busy;
    int          fail_count = 0;
    int          checks     = 0;

    eac_if io ();
    eac_dev #(.ATOMIC_TICKS(8), .SPLIT_TICKS(4)) i_eac_dev (.clk_i(clk_i), .rst_i(rst_i),
        .io(io), .flash_selfprog_active_i(selfprog), .flash_store_op_i(store),
        .prog_busy_o(busy));
    eac_host i_eac_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .flash_selfprog_active_i(selfprog),
        .irq_o(irq), .io(io));
    eac_io_assertions #(.ATOMIC_TICKS(8), .SPLIT_TICKS(4)) i_eac_io_assertions (
        .clk_i(clk_i), .rst_i(rst_i), .io_addr(io.io_addr), .io_wr(io.io_wr),
        .io_rd(io.io_rd), .io_wdata(io.io_wdata), .io_rdata(io.io_rdata), .stall(io.stall),
        .irq(io.irq), .prog_busy_o(busy), .flash_store_op_i(store));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        if (fail_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic bad(input string what);
        fail_count++;
        $display("unexpected at %0t: %s", $time, what);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) bad($sformatf("%s got %h want %h", what, got, exp));
    endtask

    // one classic wishbone cycle, read data left in rd
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (n >= 50) begin
            bad("bus timeout");
            print_verdict();
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, HW_STAT, 32'h0);
            n++;
        end while (rd[STAT_BUSY] !== 1'b0 && n < 400);
        if (n >= 400) begin
            bad("idle timeout");
            print_verdict();
        end
    endtask

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 2000) begin
            bad("busy timeout");
            print_verdict();
        end
    endtask

    task automatic start_prog(input logic [8:0] idx, input logic [7:0] v, input logic [1:0] m);
        wb(1'b1, HW_INDEX, {23'h0, idx});
        wb(1'b1, HW_DATA, {24'h0, v});
        wb(1'b1, HW_CMD, {26'h0, m, 4'h1});
    endtask

    task automatic prog_byte(input logic [8:0] idx, input logic [7:0] v, input logic [1:0] m);
        start_prog(idx, v, m);
        wait_idle();
    endtask

    task automatic read_check(input logic [8:0] idx, input logic [7:0] exp);
        wb(1'b1, HW_INDEX, {23'h0, idx});
        wb(1'b1, HW_CMD, 32'h2);
        wait_idle();
        wb(1'b0, HW_DATA, 32'h0);
        check({24'h0, rd[7:0]}, {24'h0, exp}, "read byte");
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, HW_CFG, 32'h3);
        wb(1'b0, HW_CFG, 32'h0);
        check(rd, 32'h3, "cfg");
        wb(1'b1, 8'h14, 32'hFFFF_FFFF);
        wb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0, "unmapped");
        prog_byte(9'h1A5, 8'h3C, PM_ATOMIC);
        read_check(9'h1A5, 8'h3C);
        check({31'h0, irq}, 32'h1, "idle irq");
        wb(1'b0, HW_STAT, 32'h0);
        check(rd, 32'h6, "status after read");
        prog_byte(9'h000, 8'h11, PM_ATOMIC);
        prog_byte(9'h1FF, 8'h22, PM_ATOMIC);
        read_check(9'h000, 8'h11);
        read_check(9'h1FF, 8'h22);
        prog_byte(9'h1A5, 8'h00, PM_ERASE);
        read_check(9'h1A5, ERASED_BYTE);
        prog_byte(9'h1A5, 8'h5A, PM_WRITE);
        prog_byte(9'h1A5, 8'h0F, PM_WRITE);
        read_check(9'h1A5, 8'h0A);
        prog_byte(9'h1A5, 8'h77, PM_RSVD);
        read_check(9'h1A5, 8'h0A);
        store <= 1'b1;
        prog_byte(9'h1A5, 8'h99, PM_ATOMIC);
        check({31'h0, irq}, 32'h0, "irq in store");
        store <= 1'b0;
        read_check(9'h1A5, 8'h0A);
        start_prog(9'h0F0, 8'hA5, PM_ATOMIC);
        wait_busy(1'b1);
        @(posedge clk_i);
        check({31'h0, irq}, 32'h0, "irq in program");
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({31'h0, busy}, 32'h1, "busy after reset");
        wait_busy(1'b0);
        read_check(9'h0F0, 8'hA5);
        selfprog <= 1'b1;
        start_prog(9'h0F1, 8'h66, PM_ATOMIC);
        repeat (100) @(posedge clk_i);
        check({31'h0, busy}, 32'h0, "busy in selfprog");
        selfprog <= 1'b0;
        wait_idle();
        read_check(9'h0F1, 8'h66);
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        bad("run timeout");
        print_verdict();
    end
endmodule // eac_bench

`default_nettype wire
